// ---- design/acw_pkg.sv ----
// Behaviour
// - Band-gap runs while request bit set and converter enabled and active.
// - Write mode 10: results not stored, compare match still interrupts.
// - Compare-only validity and interrupt timing follow compare and scan modes.
// - Write mode 01: store result at its channel slot, compare stays active.
// - Write mode 00: legacy store at buffer pointer position.
package acw_pkg;
    localparam logic [7:0]  ACW_CTRL_ADDR   = 8'h00;
    localparam logic [7:0]  ACW_STAT_ADDR   = 8'h04;
    localparam logic [7:0]  ACW_BUF_BASE    = 8'h40;
    localparam int          ACW_ADDR_W      = 8;
    localparam int          ACW_CTRL_W      = 16;
    localparam logic [15:0] ACW_CTRL_RESET  = 16'h0000;
    localparam int          ACW_BGR_BIT     = 12;
    localparam int          ACW_SIM_LSB     = 8;
    localparam int          ACW_WR_LSB      = 2;
    localparam int          ACW_CMP_LSB     = 0;
    localparam int          ACW_ST_BG_BIT   = 0;
    localparam int          ACW_ST_MP_BIT   = 1;
    localparam int          ACW_ST_PTR_LSB  = 8;
    localparam logic [1:0]  ACW_WR_LEGACY   = 2'h0;
    localparam logic [1:0]  ACW_WR_SAVE     = 2'h1;
    localparam logic [1:0]  ACW_WR_CMP_ONLY = 2'h2;
    localparam logic [1:0]  ACW_CMP_GREATER = 2'h1;
    localparam logic [1:0]  ACW_SIM_NONE    = 2'h0;
    localparam logic [1:0]  ACW_SIM_DONE    = 2'h1;
    localparam logic [1:0]  ACW_SIM_MATCH   = 2'h2;
    localparam logic [1:0]  ACW_SIM_BOTH    = 2'h3;
    localparam logic [1:0]  ACW_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  ACW_RESP_SLVERR = 2'h2;
endpackage : acw_pkg

// ---- design/acw_top.sv ----
`timescale 1ns/1ps
module acw_top
    import acw_pkg::*;
#(
    parameter int DEPTH = 16,
    parameter int DW    = 12
) (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [ACW_ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [ACW_ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic                   conv_enable,
    input  wire logic                   conv_active,
    input  wire logic                   result_valid,
    input  wire logic [DW-1:0]          result_data,
    input  wire logic [$clog2(DEPTH)-1:0] result_chan,
    input  wire logic                   scan_done,
    output logic                        bandgap_on,
    output logic                        compare_irq,
    output logic                        compare_match
);
    localparam int CW = $clog2(DEPTH);

    typedef struct packed {
        logic [ACW_CTRL_W-1:0]      ctrl;
        logic [DEPTH-1:0][DW-1:0]   bufs;
        logic [CW-1:0]              ptr;
        logic                       match_pend;
        logic                       match;
        logic                       irq;
        logic                       bg;
        logic                       aw_held;
        logic [ACW_ADDR_W-1:0]      aw_addr;
        logic                       w_held;
        logic [31:0]                w_data;
        logic [3:0]                 w_strb;
        logic                       bvalid;
        logic [1:0]                 bresp;
        logic                       rvalid;
        logic [1:0]                 rresp;
        logic [31:0]                rdata;
    } acw_state_t;

    acw_state_t st_reg;
    acw_state_t st_next;

    // Buffer window decode, shared by read and write paths
    function automatic logic is_buf(input logic [ACW_ADDR_W-1:0] a);
        logic [ACW_ADDR_W-1:0] top;
        top = ACW_BUF_BASE + ACW_ADDR_W'(DEPTH * 4);
        return (a >= ACW_BUF_BASE) && (a < top) && (a[1:0] == 2'h0);
    endfunction : is_buf

    function automatic logic [CW-1:0] buf_idx(input logic [ACW_ADDR_W-1:0] a);
        logic [ACW_ADDR_W-1:0] off;
        off = a - ACW_BUF_BASE;
        return off[CW+1:2];
    endfunction : buf_idx

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    logic [1:0]    wr_mode;
    logic [1:0]    cmp_mode;
    logic [1:0]    sim;
    logic          cmp_on;
    logic          hit;
    logic [DW-1:0] thresh;

    assign wr_mode  = st_reg.ctrl[ACW_WR_LSB +: 2];
    assign cmp_mode = st_reg.ctrl[ACW_CMP_LSB +: 2];
    assign sim      = st_reg.ctrl[ACW_SIM_LSB +: 2];
    assign thresh   = st_reg.bufs[result_chan];
    // Legacy mode stores without judging thresholds
    assign cmp_on   = (wr_mode == ACW_WR_SAVE)
                      || (wr_mode == ACW_WR_CMP_ONLY);
    assign hit      = result_valid && cmp_on
                      && (cmp_mode == ACW_CMP_GREATER)
                      && (result_data > thresh);

    always_comb begin
        logic [31:0]           cur;
        logic                  do_wr;
        logic [ACW_ADDR_W-1:0] ra;
        cur     = 32'h0000_0000;
        ra      = s_axi_araddr;
        st_next = st_reg;
        do_wr   = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;

        st_next.bg = st_reg.ctrl[ACW_BGR_BIT] && conv_enable
                     && conv_active;

        // Result storage by write mode
        if (result_valid) begin
            if (wr_mode == ACW_WR_LEGACY) begin
                st_next.bufs[st_reg.ptr] = result_data;
                st_next.ptr = (st_reg.ptr == CW'(DEPTH - 1)) ? '0
                              : st_reg.ptr + CW'(1);
            end else if (wr_mode == ACW_WR_SAVE) begin
                st_next.bufs[result_chan] = result_data;
            end
            // Compare-only and reserved code leave buffers alone
        end

        // Interrupt decision; a match in the done cycle still counts
        st_next.match = hit;
        st_next.irq   = 1'b0;
        case (sim)
            ACW_SIM_MATCH: st_next.irq = hit;
            ACW_SIM_DONE:  st_next.irq = scan_done;
            ACW_SIM_BOTH:  st_next.irq = scan_done
                                         && (st_reg.match_pend || hit);
            default:       st_next.irq = 1'b0;
        endcase
        if (scan_done) begin
            st_next.match_pend = 1'b0;
        end else if (hit) begin
            st_next.match_pend = 1'b1;
        end

        // AXI write channel capture, either order
        if (s_axi_awvalid && s_axi_awready) begin
            st_next.aw_held = 1'b1;
            st_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_next.w_held = 1'b1;
            st_next.w_data = s_axi_wdata;
            st_next.w_strb = s_axi_wstrb;
        end
        if (do_wr) begin
            st_next.aw_held = 1'b0;
            st_next.w_held  = 1'b0;
            st_next.bvalid  = 1'b1;
            st_next.bresp   = ACW_RESP_OKAY;
            // Software write wins over a same-cycle result store
            if (st_reg.aw_addr == ACW_CTRL_ADDR) begin
                cur = merge({16'h0000, st_reg.ctrl}, st_reg.w_data,
                            st_reg.w_strb);
                st_next.ctrl = cur[ACW_CTRL_W-1:0];
            end else if (st_reg.aw_addr == ACW_STAT_ADDR) begin
                st_next.bresp = ACW_RESP_OKAY;
            end else if (is_buf(st_reg.aw_addr)) begin
                cur = merge({{(32-DW){1'b0}},
                             st_reg.bufs[buf_idx(st_reg.aw_addr)]},
                            st_reg.w_data, st_reg.w_strb);
                st_next.bufs[buf_idx(st_reg.aw_addr)] = cur[DW-1:0];
            end else begin
                st_next.bresp = ACW_RESP_SLVERR;
            end
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end

        // AXI read channel
        if (s_axi_arvalid && s_axi_arready) begin
            st_next.rvalid = 1'b1;
            st_next.rresp  = ACW_RESP_OKAY;
            st_next.rdata  = 32'h0000_0000;
            if (ra == ACW_CTRL_ADDR) begin
                st_next.rdata[ACW_CTRL_W-1:0] = st_reg.ctrl;
            end else if (ra == ACW_STAT_ADDR) begin
                st_next.rdata[ACW_ST_BG_BIT] = st_reg.bg;
                st_next.rdata[ACW_ST_MP_BIT] = st_reg.match_pend;
                st_next.rdata[ACW_ST_PTR_LSB +: CW] = st_reg.ptr;
            end else if (is_buf(ra)) begin
                st_next.rdata[DW-1:0] = st_reg.bufs[buf_idx(ra)];
            end else begin
                st_next.rresp = ACW_RESP_SLVERR;
            end
        end else if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg      <= '0;
            st_reg.ctrl <= ACW_CTRL_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign s_axi_awready = !st_reg.aw_held && !st_reg.bvalid;
    assign s_axi_wready  = !st_reg.w_held && !st_reg.bvalid;
    assign s_axi_arready = !st_reg.rvalid;
    assign s_axi_bvalid  = st_reg.bvalid;
    assign s_axi_bresp   = st_reg.bresp;
    assign s_axi_rvalid  = st_reg.rvalid;
    assign s_axi_rresp   = st_reg.rresp;
    assign s_axi_rdata   = st_reg.rdata;
    assign bandgap_on    = st_reg.bg;
    assign compare_irq   = st_reg.irq;
    assign compare_match = st_reg.match;

    a_bandgap_follow: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ##1 bandgap_on == $past(st_reg.ctrl[ACW_BGR_BIT] && conv_enable
                                && conv_active))
        else $error("bandgap output does not follow request");

    a_cmp_only_nostore: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (result_valid && wr_mode == ACW_WR_CMP_ONLY && !st_reg.aw_held)
        |=> $stable(st_reg.bufs))
        else $error("compare-only mode changed a buffer");

    a_match_irq: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (hit && sim == ACW_SIM_MATCH) |=> compare_irq && compare_match)
        else $error("valid match did not interrupt");

    a_irq_cause: assert property (
        @(posedge aclk) disable iff (!aresetn)
        compare_irq |-> $past(scan_done) || $past(hit))
        else $error("interrupt without scan end or match");

    a_save_slot: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (result_valid && wr_mode == ACW_WR_SAVE && !st_next.w_held
         && !st_reg.w_held)
        |=> st_reg.bufs[$past(result_chan)] == $past(result_data))
        else $error("save mode did not store at channel slot");

    a_legacy_ptr: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (result_valid && wr_mode == ACW_WR_LEGACY && !st_reg.w_held)
        |=> st_reg.bufs[$past(st_reg.ptr)] == $past(result_data)
            && st_reg.ptr != $past(st_reg.ptr))
        else $error("legacy store or pointer advance wrong");

    a_greater_only: assert property (
        @(posedge aclk) disable iff (!aresetn)
        compare_match |-> $past(result_data) > $past(thresh)
                          && $past(cmp_mode) == ACW_CMP_GREATER)
        else $error("match declared without strict greater");

    a_write_answer: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid)
        |=> s_axi_bvalid)
        else $error("write not answered");

    a_resp_hold: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
        else $error("write response dropped before taken");

    a_read_answer: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
        else $error("read not answered");

    a_legacy_nocmp: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (result_valid && wr_mode == ACW_WR_LEGACY) |=> !compare_match)
        else $error("legacy mode declared a match");

    a_cmp_only_irq: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (result_valid && wr_mode == ACW_WR_CMP_ONLY
         && cmp_mode == ACW_CMP_GREATER && result_data > thresh
         && sim == ACW_SIM_MATCH)
        |=> compare_irq)
        else $error("compare-only match did not interrupt");

    a_done_irq: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (scan_done && sim == ACW_SIM_DONE) |=> compare_irq)
        else $error("scan end did not interrupt");

    a_both_irq: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (scan_done && sim == ACW_SIM_BOTH
         && (st_reg.match_pend || hit))
        |=> compare_irq)
        else $error("scan end after a match did not interrupt");

    a_save_match: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (result_valid && wr_mode == ACW_WR_SAVE
         && cmp_mode == ACW_CMP_GREATER && result_data > thresh)
        |=> compare_match)
        else $error("save mode lost a valid match");
endmodule : acw_top

// ---- testbench/adc_compare_write_mode_test.sv ----
`timescale 1ns/1ps
module adc_compare_write_mode_test;
    import acw_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, conv_enable;
    logic conv_active, result_valid, scan_done, bandgap_on;
    logic compare_irq, compare_match;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb, result_chan;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [11:0] result_data;
    int          fail_count, cmp_count;
    logic [1:0]  rsp;
    logic [31:0] rd;
    logic        m, i;

    acw_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conv_enable,
        .conv_active, .result_valid, .result_data, .result_chan,
        .scan_done, .bandgap_on, .compare_irq, .compare_match);

    initial begin
        aclk = 0;
        forever #12.5 aclk = ~aclk;
    end

    task end_sim;
        if (fail_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task hang;
        fail_count++;
        $display("mismatch at %0t: no bus answer", $time);
        end_sim();
    endtask : hang

    // Readiness judged at negedge: inputs only move at posedge
    task wr(input logic [7:0] a, input logic [31:0] d);
        bit aw, w;
        aw = 0;
        w = 0;
        s_axi_awaddr <= a; s_axi_wdata <= d;
        s_axi_awvalid <= 1; s_axi_wvalid <= 1;
        for (int n = 0; !(aw && w); n++) begin
            if (n > 40) hang();
            @(negedge aclk);
            if (s_axi_awready && s_axi_awvalid) aw = 1;
            if (s_axi_wready && s_axi_wvalid) w = 1;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 0;
            if (w) s_axi_wvalid <= 0;
        end
        s_axi_bready <= 1;
        for (int n = 0; 1; n++) begin
            if (n > 40) hang();
            @(negedge aclk);
            rsp = s_axi_bresp;
            if (s_axi_bvalid) break;
            @(posedge aclk);
        end
        @(posedge aclk);
        s_axi_bready <= 0;
    endtask : wr

    task rdw(input logic [7:0] a);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        for (int n = 0; 1; n++) begin
            if (n > 40) hang();
            @(negedge aclk);
            if (s_axi_arready) break;
            @(posedge aclk);
        end
        @(posedge aclk);
        s_axi_arvalid <= 0;
        for (int n = 0; 1; n++) begin
            if (n > 40) hang();
            @(negedge aclk);
            rd = s_axi_rdata; rsp = s_axi_rresp;
            if (s_axi_rvalid) break;
            @(posedge aclk);
        end
        @(posedge aclk);
        s_axi_rready <= 0;
    endtask : rdw

    // One converter event; match and irq looked at in their one cycle
    task ev(input logic v, s, input logic [3:0] c, input logic [11:0] d);
        result_valid <= v; scan_done <= s; result_chan <= c; result_data <= d;
        @(posedge aclk);
        result_valid <= 0; scan_done <= 0;
        @(negedge aclk);
        m = compare_match; i = compare_irq;
        @(posedge aclk);
    endtask : ev

    // Reserved write code 11 is never built here
    function automatic logic [31:0] ctl(logic [1:0] sim, wmode, cmode);
        return (32'(sim) << ACW_SIM_LSB) | (32'(wmode) << ACW_WR_LSB)
               | (32'(cmode) << ACW_CMP_LSB);
    endfunction : ctl

    // Looked at mid-cycle, clear of the edge that updates it
    task bg_chk(input logic exp);
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        chk(bandgap_on, exp);
        @(posedge aclk);
    endtask : bg_chk

    task bandgap_case;
        conv_enable <= 1;
        wr(ACW_CTRL_ADDR, 32'h1 << ACW_BGR_BIT);
        chk(rsp, ACW_RESP_OKAY);
        bg_chk(0);
        conv_active <= 1;
        bg_chk(1);
        rdw(ACW_STAT_ADDR);
        chk(rsp, ACW_RESP_OKAY);
        chk(rd[ACW_ST_BG_BIT], 1);
        conv_enable <= 0;
        bg_chk(0);
    endtask : bandgap_case

    task legacy_case;
        wr(ACW_CTRL_ADDR, ctl(ACW_SIM_MATCH, ACW_WR_LEGACY, ACW_CMP_GREATER));
        ev(1, 0, 4'h5, 12'habc);
        chk({m, i}, 2'b00);
        ev(1, 0, 4'h9, 12'h123);
        rdw(ACW_BUF_BASE);
        chk(rd, 32'habc);
        rdw(ACW_BUF_BASE + 8'h04);
        chk(rd, 32'h123);
    endtask : legacy_case

    task save_case;
        wr(ACW_CTRL_ADDR, ctl(ACW_SIM_MATCH, ACW_WR_SAVE, ACW_CMP_GREATER));
        wr(ACW_BUF_BASE + 8'h08, 32'h100);
        ev(1, 0, 4'h2, 12'h101);
        chk({m, i}, 2'b11);
        rdw(ACW_BUF_BASE + 8'h08);
        chk(rd, 32'h101);
        ev(1, 0, 4'h2, 12'h101);
        chk({m, i}, 2'b00);
        ev(1, 0, 4'h2, 12'h100);
        chk({m, i}, 2'b00);
    endtask : save_case

    task cmp_only_case;
        wr(ACW_CTRL_ADDR, ctl(ACW_SIM_BOTH, ACW_WR_CMP_ONLY, ACW_CMP_GREATER));
        wr(ACW_BUF_BASE + 8'h0c, 32'h50);
        ev(1, 0, 4'h3, 12'h60);
        chk({m, i}, 2'b10);
        rdw(ACW_BUF_BASE + 8'h0c);
        chk(rd, 32'h50);
        ev(0, 1, 4'h0, 12'h0);
        chk(i, 1);
        ev(0, 1, 4'h0, 12'h0);
        chk(i, 0);
    endtask : cmp_only_case

    task scan_irq_case;
        wr(ACW_CTRL_ADDR, ctl(ACW_SIM_DONE, ACW_WR_CMP_ONLY, ACW_CMP_GREATER));
        ev(1, 0, 4'h3, 12'h60);
        chk({m, i}, 2'b10);
        ev(0, 1, 4'h0, 12'h0);
        chk(i, 1);
        wr(ACW_CTRL_ADDR,
           ctl(ACW_SIM_MATCH, ACW_WR_CMP_ONLY, ACW_CMP_GREATER));
        ev(1, 0, 4'h3, 12'h60);
        chk({m, i}, 2'b11);
    endtask : scan_irq_case

    task bus_case;
        rdw(ACW_CTRL_ADDR);
        chk(rd, {16'h0, ACW_CTRL_RESET});
        wr(8'h20, 32'hffff);
        chk(rsp, ACW_RESP_SLVERR);
        rdw(8'h20);
        chk(rsp, ACW_RESP_SLVERR);
        chk(rd, 32'h0);
    endtask : bus_case

    initial begin
        fail_count = 0; cmp_count = 0;
        aresetn = 0; s_axi_awvalid = 0; s_axi_wvalid = 0; s_axi_bready = 0;
        s_axi_arvalid = 0; s_axi_rready = 0; s_axi_awaddr = 0;
        s_axi_araddr = 0; s_axi_wdata = 0; s_axi_wstrb = 4'hf;
        conv_enable = 0; conv_active = 0; result_valid = 0; scan_done = 0;
        result_chan = 0; result_data = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        bus_case();
        bandgap_case();
        legacy_case();
        save_case();
        cmp_only_case();
        scan_irq_case();
        end_sim();
    end
endmodule : adc_compare_write_mode_test
